// >>> logic/serial_link_autoneg.sv
// Purpose: Configuration-word negotiation for a 1.25 Gbps serial link, 1000BASE-X or SGMII.
// Assumes: Management requests arrive decoded, one per cycle; rx words are pre-decoded.
// Notes: Arbitration of abilities is left to software.
//
// What this block does
// R1: Exchange starts only when restart is written one while enable is one.
// R2: Send advertise word repeatedly with acknowledge bit 14 clear.
// R3: Nonzero received word sets acknowledge, stores partner word, sets page flags.
// R4: Stop sending on link timer expiry: 10 ms 1000BASE-X, 1.6 ms SGMII.
// R5: Standard-select chooses link timer: one 1000BASE-X, zero SGMII.
// R6: Next page unsupported; software writes zero to bit 15.
// R7: Watchdog restarts negotiation after 5 s without link unless disabled.
// R8: Link-down outside disabled-ok and link-ok; clears latched status, squelches clocks.
// R9: Software sets remote fault 11 and restarts on no ability overlap.
// R10: Software selects 1000BASE-X by setting standard-select and enable.
// R11: Straps at reset select 1000BASE-X with negotiation enabled.
// R12: Straps with output two low select SGMII; speed from straps or 10.
// R13: 1000BASE-X advertise default is full duplex only, no pause, no fault.
// R14: Remote fault field bits 13:12 encodes four conditions, resets 00.
// R15: Pause field bits 8:7 encodes four abilities, resets 00.
// R16: Half duplex bit 6 written zero; bit 5 advertises full duplex.
// R17: Reserved bits sent zero in 1000BASE-X; hardware makes acknowledge.
// R18: Standard-select clear gives SGMII transfer on same machinery.
// R19: As SGMII receiver software writes advertise 0x0001; words stored.
// R20: SGMII advertise default reports full duplex and link up.
// R21: SGMII word carries link status, speed and duplex.
// R22: Software reads partner ability, resolves, configures data path.
`timescale 1ns/1ps
`include "autoneg_map.svh"

module serial_link_autoneg #(
    parameter int LINK_TIMER_STANDARD_SELECT = `LINK_TIMER_STANDARD_SELECT_US * `CYCLES_PER_US,
    parameter int LINK_TIMER_SGMII = `LINK_TIMER_SGMII_US * `CYCLES_PER_US,
    parameter int WATCHDOG_CYCLES = `WATCHDOG_US * `CYCLES_PER_US
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire autoneg_pkg::strap_type straps,
    input wire autoneg_pkg::mgmt_req_type mgmt_req,
    output autoneg_pkg::config_word_type tx_config,
    input wire autoneg_pkg::config_word_type rx_config,
    input wire logic link_sync_ok,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    output logic link_down,
    output logic clock_squelch
);
    import autoneg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Storage.
    an_state_type state_reg, state_next;
    logic strap_done_reg;
    logic negotiation_enable_reg;
    logic negotiation_restart_reg;
    logic standard_select_reg;
    logic watchdog_disable_reg;
    logic clock_squelch_enable_reg;
    logic [15:0] advertise_register_reg;
    logic [15:0] partner_ability_register_reg;
    logic page_expansion_reg;
    logic page_interrupt_reg;
    logic link_status_latched_reg;
    logic [31:0] link_timer_reg;
    logic [31:0] watchdog_reg;
    logic strap_enable;
    logic [1:0] strap_speed;
    logic page_event;
    logic link_timer_done;
    logic watchdog_fire;
    logic negotiating;
    logic ok_state;
    logic start_request;
    logic wr_control;
    logic rd_status;
    logic rd_expansion;
    logic rd_interrupt;
    logic [31:0] link_timer_limit;
    logic [15:0] tx_word;

    ////////////////////////////////////////////////////////////////////////////
    // Strap decode, caught once in the first cycle after reset release.
    always_comb begin
        strap_enable = 1'b0;
        strap_speed = `SPEED_1000;
        if (straps.collision) begin
            strap_enable = 1'b1; // R11
        end else if (straps.rx_data == `STRAP_RXD_MATCH && straps.rx_valid) begin
            strap_enable = 1'b1; // R11
            strap_speed = straps.rx_data; // R12
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strap_done_reg <= 1'b0;
        end else begin
            strap_done_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request decode.
    assign wr_control = mgmt_req.write && mgmt_req.addr == `ADDR_BASIC_CONTROL;
    assign rd_status = mgmt_req.read && mgmt_req.addr == `ADDR_BASIC_STATUS;
    assign rd_expansion = mgmt_req.read && mgmt_req.addr == `ADDR_EXPANSION;
    assign rd_interrupt = mgmt_req.read && mgmt_req.addr == `ADDR_INTERRUPT;

    ////////////////////////////////////////////////////////////////////////////
    // Control bits. Enable and standard-select ignore writes in the capture cycle, where straps may load them.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            negotiation_enable_reg <= 1'b0;
            standard_select_reg <= 1'b1;
        end else if (!strap_done_reg) begin
            if (strap_enable) begin
                negotiation_enable_reg <= 1'b1; // R11
                standard_select_reg <= straps.general_output_two; // R12
            end
        end else begin
            if (wr_control) begin
                negotiation_enable_reg <= mgmt_req.wdata[`BIT_NEG_ENABLE];
            end
            if (mgmt_req.write && mgmt_req.addr == `ADDR_CODING_CONTROL) begin
                standard_select_reg <= mgmt_req.wdata[`BIT_STANDARD_SELECT]; // R18
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            watchdog_disable_reg <= 1'b0;
            clock_squelch_enable_reg <= 1'b0;
        end else if (mgmt_req.write && mgmt_req.addr == `ADDR_CODING_CONTROL) begin
            watchdog_disable_reg <= mgmt_req.wdata[`BIT_WATCHDOG_DISABLE]; // R7
        end else if (mgmt_req.write && mgmt_req.addr == `ADDR_GENERAL_CONTROL) begin
            clock_squelch_enable_reg <= mgmt_req.wdata[`BIT_CLOCK_SQUELCH];
        end
    end

    // Restart is a one-cycle self-clearing bit; it never reads back as one.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            negotiation_restart_reg <= 1'b0;
        end else begin
            negotiation_restart_reg <= wr_control && mgmt_req.wdata[`BIT_NEG_RESTART];
        end
    end

    // The enable seen with the restart is the one written in the same word.
    assign start_request = negotiation_restart_reg && negotiation_enable_reg; // R1

    ////////////////////////////////////////////////////////////////////////////
    // Advertisement register. Bit 14 is reserved and always reads zero.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            advertise_register_reg <= `ADV_RESET_STANDARD_SELECT; // R13 R14 R15
        end else if (!strap_done_reg) begin
            if (strap_enable && !straps.general_output_two) begin
                advertise_register_reg <= `ADV_RESET_SGMII; // R20
                advertise_register_reg[`SPEED_LSB +: 2] <= strap_speed; // R12
            end
        end else if (mgmt_req.write && mgmt_req.addr == `ADDR_ADVERTISE) begin
            advertise_register_reg <= mgmt_req.wdata;
            advertise_register_reg[`BIT_ACK] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timers.
    assign link_timer_limit = standard_select_reg ? LINK_TIMER_STANDARD_SELECT - 1
                                                  : LINK_TIMER_SGMII - 1; // R5
    assign link_timer_done = link_timer_reg == link_timer_limit;
    assign negotiating = state_reg == ABILITY_DETECT || state_reg == ACK_DETECT ||
                         state_reg == COMPLETE_ACK;
    assign watchdog_fire = !watchdog_disable_reg &&
                           watchdog_reg == 32'(WATCHDOG_CYCLES - 1); // R7

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            link_timer_reg <= 32'h0000_0000;
        end else if (state_reg != ACK_DETECT || link_timer_done) begin
            link_timer_reg <= 32'h0000_0000;
        end else begin
            link_timer_reg <= link_timer_reg + 32'h0000_0001; // R4
        end
    end

    // Counts from the start of an exchange until link-ok is reached.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            watchdog_reg <= 32'h0000_0000;
        end else if (!negotiating || start_request || watchdog_fire) begin
            watchdog_reg <= 32'h0000_0000;
        end else begin
            watchdog_reg <= watchdog_reg + 32'h0000_0001; // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration state machine.
    assign page_event = state_reg == ABILITY_DETECT && rx_config.valid &&
                        rx_config.word != 16'h0000; // R3

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            AN_DISABLE_LINK_OK: begin
                if (negotiation_enable_reg) begin
                    state_next = AN_ENABLE;
                end
            end
            AN_ENABLE: begin
                if (start_request) begin
                    state_next = ABILITY_DETECT; // R1
                end
            end
            ABILITY_DETECT: begin
                if (page_event) begin
                    state_next = ACK_DETECT; // R3
                end
            end
            ACK_DETECT: begin
                if (link_timer_done) begin
                    state_next = COMPLETE_ACK; // R4
                end
            end
            COMPLETE_ACK: begin
                if (link_sync_ok) begin
                    state_next = LINK_OK; // R6
                end
            end
            LINK_OK: begin
                if (!link_sync_ok) begin
                    state_next = AN_ENABLE;
                end
            end
            default: begin
                state_next = AN_DISABLE_LINK_OK;
            end
        endcase
        if (!negotiation_enable_reg) begin
            state_next = AN_DISABLE_LINK_OK;
        end else if (start_request || watchdog_fire) begin
            state_next = ABILITY_DETECT; // R1 R7
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= AN_DISABLE_LINK_OK;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Received word and page flags; a new page wins over a clearing read.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            partner_ability_register_reg <= 16'h0000;
        end else if (page_event) begin
            partner_ability_register_reg <= rx_config.word; // R3 R19
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            page_expansion_reg <= 1'b0;
            page_interrupt_reg <= 1'b0;
        end else begin
            page_expansion_reg <= page_event || (page_expansion_reg && !rd_expansion); // R3
            page_interrupt_reg <= page_event || (page_interrupt_reg && !rd_interrupt); // R3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link-down and the latched-low status bit.
    assign ok_state = state_reg == AN_DISABLE_LINK_OK || state_reg == LINK_OK;

    // A read returns the latched value and then rearms it with the present state.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            link_status_latched_reg <= 1'b0;
        end else if (rd_status) begin
            link_status_latched_reg <= ok_state;
        end else if (!ok_state) begin
            link_status_latched_reg <= 1'b0; // R8
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            link_down <= 1'b1;
            clock_squelch <= 1'b0;
        end else begin
            link_down <= !ok_state; // R8
            clock_squelch <= !ok_state && clock_squelch_enable_reg; // R8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitted configuration word.
    always_comb begin
        tx_word = advertise_register_reg;
        if (standard_select_reg) begin
            tx_word = advertise_register_reg & `STANDARD_SELECT_TX_MASK; // R16 R17
        end
        tx_word[`BIT_ACK] = state_reg == ACK_DETECT; // R2 R3 R17
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_config <= '0;
        end else begin
            tx_config.valid <= state_reg == ABILITY_DETECT || state_reg == ACK_DETECT; // R2 R4
            tx_config.word <= tx_word; // R2 R21
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the read strobe; unmapped indices read zero.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mgmt_rdata <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= mgmt_req.read;
            mgmt_rdata <= 16'h0000;
            case (mgmt_req.addr)
                `ADDR_BASIC_CONTROL: begin
                    mgmt_rdata[`BIT_NEG_ENABLE] <= negotiation_enable_reg;
                end
                `ADDR_BASIC_STATUS: begin
                    mgmt_rdata[`BIT_NEG_COMPLETE] <= state_reg == LINK_OK;
                    mgmt_rdata[`BIT_NEG_ABILITY] <= 1'b1;
                    mgmt_rdata[`BIT_LINK_LATCHED] <= link_status_latched_reg;
                end
                `ADDR_ADVERTISE: begin
                    mgmt_rdata <= advertise_register_reg;
                end
                `ADDR_PARTNER_ABILITY: begin
                    mgmt_rdata <= partner_ability_register_reg; // R22
                end
                `ADDR_EXPANSION: begin
                    mgmt_rdata[`BIT_PAGE_EXPANSION] <= page_expansion_reg;
                end
                `ADDR_CODING_CONTROL: begin
                    mgmt_rdata[`BIT_STANDARD_SELECT] <= standard_select_reg;
                    mgmt_rdata[`BIT_WATCHDOG_DISABLE] <= watchdog_disable_reg;
                end
                `ADDR_GENERAL_CONTROL: begin
                    mgmt_rdata[`BIT_CLOCK_SQUELCH] <= clock_squelch_enable_reg;
                end
                `ADDR_INTERRUPT: begin
                    mgmt_rdata[`BIT_PAGE_INTERRUPT] <= page_interrupt_reg;
                end
                default: begin
                    mgmt_rdata <= 16'h0000;
                end
            endcase
            if (!mgmt_req.read) begin
                mgmt_rdata <= 16'h0000;
            end
        end
    end

endmodule // serial_link_autoneg

// >>> logic/autoneg_map.svh
// Purpose: Register offsets, field positions, reset values and timing figures.
// Assumes: 100 MHz mclk; management registers addressed by a 5-bit index.
// Notes: Definitions only.
`ifndef AUTONEG_MAP_SVH
`define AUTONEG_MAP_SVH

`define CLK_PERIOD_NS 10
`define CYCLES_PER_US (1000 / `CLK_PERIOD_NS)
`define LINK_TIMER_STANDARD_SELECT_US 10000
`define LINK_TIMER_SGMII_US 1600
`define WATCHDOG_US 5000000

`define ADDR_BASIC_CONTROL 5'h00
`define ADDR_BASIC_STATUS 5'h01
`define ADDR_ADVERTISE 5'h04
`define ADDR_PARTNER_ABILITY 5'h05
`define ADDR_EXPANSION 5'h06
`define ADDR_CODING_CONTROL 5'h11
`define ADDR_GENERAL_CONTROL 5'h12
`define ADDR_INTERRUPT 5'h13

`define BIT_NEG_ENABLE 12
`define BIT_NEG_RESTART 9
`define BIT_NEG_COMPLETE 5
`define BIT_NEG_ABILITY 3
`define BIT_LINK_LATCHED 2
`define BIT_PAGE_EXPANSION 1
`define BIT_PAGE_INTERRUPT 0
`define BIT_STANDARD_SELECT 0
`define BIT_WATCHDOG_DISABLE 1
`define BIT_CLOCK_SQUELCH 0
`define BIT_ACK 14
`define SPEED_LSB 10

`define ADV_RESET_STANDARD_SELECT 16'h0020
`define ADV_RESET_SGMII 16'h9001
`define STANDARD_SELECT_TX_MASK 16'hb1e0
`define SPEED_1000 2'h2
`define STRAP_RXD_MATCH 2'h2

`endif

// >>> logic/autoneg_pkg.sv
// Purpose: Types shared by the negotiation block and its bench.
// Assumes: Offsets and figures live in autoneg_map.svh.
// Notes: Packed structs carry grouped signals.
package autoneg_pkg;

    typedef enum logic [2:0] {
        AN_DISABLE_LINK_OK = 3'b000,
        AN_ENABLE = 3'b001,
        ABILITY_DETECT = 3'b010,
        ACK_DETECT = 3'b011,
        COMPLETE_ACK = 3'b100,
        LINK_OK = 3'b101
    } an_state_type;

    typedef struct packed {
        logic collision;
        logic [1:0] rx_data;
        logic general_output_two;
        logic rx_valid;
    } strap_type;

    typedef struct packed {
        logic write;
        logic read;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_type;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } config_word_type;

endpackage

// >>> test/autoneg_checker_sva.sv
// Purpose: Port-level checker for the negotiation block.
// Assumes: Shortened timer parameters are handed on by the bind.
// Notes: Sees only the top module's ports.
`timescale 1ns/1ps
`include "autoneg_map.svh"
module autoneg_checker #(
    parameter int LINK_TIMER_STANDARD_SELECT = 20,
    parameter int LINK_TIMER_SGMII = 12,
    parameter int WATCHDOG_CYCLES = 200
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire autoneg_pkg::strap_type straps,
    input wire autoneg_pkg::mgmt_req_type mgmt_req,
    input wire autoneg_pkg::config_word_type tx_config,
    input wire autoneg_pkg::config_word_type rx_config,
    input wire logic link_sync_ok,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_rvalid,
    input wire logic link_down,
    input wire logic clock_squelch
);
    import autoneg_pkg::*;
    // The slower timer bounds the acknowledge phase in either mode.
    localparam int ACK_MAX = LINK_TIMER_STANDARD_SELECT + 4;
    logic ctrl_write;
    assign ctrl_write = mgmt_req.write && mgmt_req.addr == `ADDR_BASIC_CONTROL
        && mgmt_req.wdata[`BIT_NEG_RESTART];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_read_answer: assert property (mgmt_req.read |=> mgmt_rvalid)
        else $error("read got no answer");
    a_idle_quiet: assert property (!mgmt_req.read |=> !mgmt_rvalid && mgmt_rdata == 16'h0000)
        else $error("read data shown without a read");
    a_restart_starts: assert property (
        ctrl_write && mgmt_req.wdata[`BIT_NEG_ENABLE] && !tx_config.valid |-> ##4 tx_config.valid)
        else $error("restart did not start sending");
    a_restart_refused: assert property (
        ctrl_write && !mgmt_req.wdata[`BIT_NEG_ENABLE] && !tx_config.valid
        |=> !tx_config.valid [*3])
        else $error("restart without enable started sending");
    a_page_acks: assert property (
        rx_config.valid && rx_config.word != 16'h0000 && tx_config.valid && !tx_config.word[`BIT_ACK]
        |-> ##2 tx_config.valid && tx_config.word[`BIT_ACK])
        else $error("page not acknowledged");
    a_ack_holds: assert property ($rose(tx_config.word[`BIT_ACK]) |-> tx_config.valid [*8])
        else $error("acknowledge phase cut short");
    a_timer_expiry: assert property (
        $rose(tx_config.word[`BIT_ACK]) |-> ##[1:ACK_MAX] !tx_config.valid)
        else $error("sending did not stop at timer expiry");
    a_down_while_sending: assert property (tx_config.valid |-> link_down)
        else $error("link shown up while sending words");
    a_squelch_needs_down: assert property (clock_squelch |-> link_down)
        else $error("clocks squelched with link up");
endmodule // autoneg_checker

bind serial_link_autoneg autoneg_checker #(
    .LINK_TIMER_STANDARD_SELECT(LINK_TIMER_STANDARD_SELECT),
    .LINK_TIMER_SGMII(LINK_TIMER_SGMII),
    .WATCHDOG_CYCLES(WATCHDOG_CYCLES)
) i_autoneg_checker (
    .mclk(mclk), .rstn(rstn), .straps(straps), .mgmt_req(mgmt_req),
    .tx_config(tx_config), .rx_config(rx_config), .link_sync_ok(link_sync_ok),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .link_down(link_down),
    .clock_squelch(clock_squelch)
);

// >>> test/link_partner_model.sv
// Purpose: Far-end PCS that answers configuration words.
// Assumes: Reply word, gap and sync come from the bench.
// Notes: Off-word cycles carry the inverse of the previous word, so every second one repeats the last word.
`timescale 1ns/1ps
module link_partner_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire autoneg_pkg::config_word_type tx_config,
    input wire logic reply_en,
    input wire logic [15:0] reply_word,
    input wire logic [3:0] reply_gap,
    input wire logic sync_en,
    output autoneg_pkg::config_word_type rx_config,
    output logic link_sync_ok
);
    import autoneg_pkg::*;
    logic [3:0] gap_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gap_reg <= 4'h0;
            rx_config <= '0;
        end else if (!(reply_en && tx_config.valid)) begin
            gap_reg <= 4'h0;
            rx_config <= {1'b0, ~rx_config.word};
        end else if (gap_reg == reply_gap) begin
            // A partner repeats its page for as long as it hears words.
            gap_reg <= 4'h0;
            rx_config <= {1'b1, reply_word};
        end else begin
            gap_reg <= gap_reg + 4'h1;
            rx_config <= {1'b0, ~rx_config.word};
        end
    end
    assign link_sync_ok = sync_en;
endmodule // link_partner_model

// >>> test/serial_link_autoneg_test.sv
// Purpose: Self-checking bench for the negotiation block.
// Assumes: Shortened link timers; partner model on the serial side.
// Notes: Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`include "autoneg_map.svh"
module serial_link_autoneg_test;
    import autoneg_pkg::*;
    localparam int T_BX = 20;
    localparam int T_SG = 12;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    strap_type straps = 5'b1_00_1_0;
    mgmt_req_type mgmt_req = '0;
    config_word_type tx_config;
    config_word_type rx_config;
    logic link_sync_ok;
    logic [15:0] mgmt_rdata;
    logic mgmt_rvalid;
    logic link_down;
    logic clock_squelch;
    logic reply_en = 1'b0;
    logic [15:0] reply_word = 16'h0000;
    logic [3:0] reply_gap = 4'h3;
    logic sync_en = 1'b0;
    int fails = 0;
    int check_count = 0;

    always #5 mclk = ~mclk;
    serial_link_autoneg #(.LINK_TIMER_STANDARD_SELECT(T_BX), .LINK_TIMER_SGMII(T_SG),
        .WATCHDOG_CYCLES(200)) i_serial_link_autoneg (
        .mclk(mclk), .rstn(rstn), .straps(straps), .mgmt_req(mgmt_req),
        .tx_config(tx_config), .rx_config(rx_config), .link_sync_ok(link_sync_ok),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .link_down(link_down),
        .clock_squelch(clock_squelch));
    link_partner_model i_link_partner_model (
        .mclk(mclk), .rstn(rstn), .tx_config(tx_config), .reply_en(reply_en),
        .reply_word(reply_word), .reply_gap(reply_gap), .sync_en(sync_en),
        .rx_config(rx_config), .link_sync_ok(link_sync_ok));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] addr, input logic [15:0] data);
        @(posedge mclk);
        #1 mgmt_req = '{1'b0 + 1'b1, 1'b0, addr, data};
        @(posedge mclk);
        #1 mgmt_req = '0;
    endtask
    // The answer stands for one cycle only, so it is judged right after the taking edge.
    task automatic rd_chk(input string name, input logic [4:0] addr,
        input logic [15:0] mask, input logic [15:0] exp);
        @(posedge mclk);
        #1 mgmt_req = '{1'b0, 1'b1, addr, 16'h0000};
        @(posedge mclk);
        #1 mgmt_req = '0;
        chk("read valid", 16'h0001, {15'h0000, mgmt_rvalid});
        chk(name, exp, mgmt_rdata & mask);
    endtask
    task automatic negotiate(input logic [15:0] adv, input logic [15:0] page,
        input logic [15:0] tx_exp, input int timer);
        int n;
        wr(`ADDR_ADVERTISE, adv);
        reply_word = page;
        wr(`ADDR_BASIC_CONTROL, 16'h1200);
        repeat (3) @(posedge mclk);
        #1 chk("tx valid", 16'h0001, {15'h0000, tx_config.valid});
        chk("tx word", tx_exp, tx_config.word);
        reply_en = 1'b1;
        n = 0;
        while (tx_config.word[`BIT_ACK] !== 1'b1 && n < 60) begin
            @(posedge mclk);
            #1 n++;
        end
        chk("tx ack word", tx_exp | 16'h4000, tx_config.word);
        n = 0;
        while (tx_config.valid === 1'b1 && n < 100) begin
            @(posedge mclk);
            #1 n++;
        end
        reply_en = 1'b0;
        chk("ack span", 16'h0001, 16'(n >= timer && n <= timer + 1));
        rd_chk("partner", `ADDR_PARTNER_ABILITY, 16'hffff, page);
        rd_chk("exp page", `ADDR_EXPANSION, 16'h0002, 16'h0002);
        rd_chk("int page", `ADDR_INTERRUPT, 16'h0001, 16'h0001);
        rd_chk("exp cleared", `ADDR_EXPANSION, 16'h0002, 16'h0000);
    endtask
    task automatic reset_values();
        rd_chk("adv reset", `ADDR_ADVERTISE, 16'hffff, 16'h0020);
        rd_chk("coding reset", `ADDR_CODING_CONTROL, 16'h0003, 16'h0001);
        rd_chk("enable reset", `ADDR_BASIC_CONTROL, 16'h1000, 16'h1000);
    endtask
    task automatic standard_select_link();
        wr(`ADDR_GENERAL_CONTROL, 16'h0001);
        wr(`ADDR_CODING_CONTROL, 16'h0001);
        // Low reserved bits written on purpose: they must not reach the wire.
        negotiate(16'h31bf, 16'h01a0, 16'h31a0, T_BX);
        chk("down at complete", 16'h0001, {15'h0000, link_down});
        chk("squelch on", 16'h0001, {15'h0000, clock_squelch});
        sync_en = 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk("down at link ok", 16'h0000, {15'h0000, link_down});
        chk("squelch off", 16'h0000, {15'h0000, clock_squelch});
        rd_chk("status latched", `ADDR_BASIC_STATUS, 16'h0024, 16'h0020);
        rd_chk("status rearmed", `ADDR_BASIC_STATUS, 16'h0024, 16'h0024);
    endtask
    task automatic restart_refused();
        wr(`ADDR_BASIC_CONTROL, 16'h0200);
        repeat (5) @(posedge mclk);
        #1 chk("no send", 16'h0000, {15'h0000, tx_config.valid});
        chk("disabled ok", 16'h0000, {15'h0000, link_down});
    endtask
    task automatic sgmii_link();
        reply_gap = 4'hc;
        wr(`ADDR_CODING_CONTROL, 16'h0000);
        negotiate(16'h0001, 16'hd801, 16'h0001, T_SG);
    endtask
    task automatic strap_cases();
        strap_type s [4] = '{5'b1_00_1_0, 5'b1_01_0_0, 5'b0_10_0_1, 5'b0_01_1_1};
        logic [15:0] adv [4] = '{16'h0020, 16'h9801, 16'h9801, 16'h0020};
        logic [15:0] std [4] = '{16'h0001, 16'h0000, 16'h0000, 16'h0001};
        logic [15:0] en [4] = '{16'h1000, 16'h1000, 16'h1000, 16'h0000};
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            #1 rstn = 1'b0;
            straps = s[i];
            repeat (2) @(posedge mclk);
            #1 rstn = 1'b1;
            @(posedge mclk);
            rd_chk("strap adv", `ADDR_ADVERTISE, 16'hffff, adv[i]);
            rd_chk("strap std", `ADDR_CODING_CONTROL, 16'h0001, std[i]);
            rd_chk("strap en", `ADDR_BASIC_CONTROL, 16'h1000, en[i]);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk);
        #1 rstn = 1'b1;
        @(posedge mclk);
        reset_values();
        standard_select_link();
        restart_refused();
        sgmii_link();
        strap_cases();
        give_verdict();
    end
    // The whole sequence needs about 150 cycles; twenty thousand means a hang.
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule // serial_link_autoneg_test
